//--- pmc_consts.svh
// register offsets, field positions, reset values and event encodings
// assumes inclusion by the counter package and the bus checker
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH
`define PMC_NCNT 4
`define PMC_CW 32
`define PMC_ADDR_W 8
`define PMC_OFF_CAP 8'h00
`define PMC_OFF_CCAP 8'h04
`define PMC_OFF_IRQ_CTL 8'h08
`define PMC_OFF_IRQ_STS 8'h0C
`define PMC_OFF_OVF_STS 8'h10
`define PMC_OFF_CMD 8'h14
`define PMC_OFF_RESP 8'h18
`define PMC_OFF_EVENT 8'h1C
`define PMC_OFF_CFG0 8'h40
`define PMC_OFF_FLT0 8'h50
`define PMC_OFF_CNT0 8'h60
`define PMC_CAP_RESET 32'h0001_0437
`define PMC_CCAP_RESET 32'h0000_0000
`define PMC_CAP_IOS_BIT 0
`define PMC_CAP_GFS_BIT 1
`define PMC_CAP_FLT_LSB 2
`define PMC_CAP_EGC_LSB 8
`define PMC_CCAP_PCC_BIT 31
`define PMC_CFG_EN_BIT 31
`define PMC_CFG_IOV_BIT 30
`define PMC_CFG_GFO_BIT 29
`define PMC_CFG_EGI_LSB 28
`define PMC_CFG_ES_W 28
`define PMC_FLT_W 3
`define PMC_EGC_MAX 4'hF
`define PMC_MASK_G0 28'h000_006F
`define PMC_MASK_G1 28'h000_0061
`define PMC_MASK_G2 28'h000_00FF
`define PMC_MASK_G4 28'h000_0007
`define PMC_FLT_G0 28'h000_0002
`define PMC_FLT_G2 28'h000_00A0
`define PMC_RESP_OK 2'h1
`define PMC_RESP_ERR 2'h2
`define PMC_RESP_IDLE 2'h0
`endif

//--- pmc_counters.sv
// counter enable checks, overflow status and interrupt pending
// assumes a classic wishbone master and event pulses on clk_i
// Notes on behaviour
// - enable command runs all checks; any failure posts error response.
// - all checks pass: post success and set counter enable bit.
// - counter index beyond implemented counters is an error.
// - several events selected with any filter enabled is an error.
// - event group unsupported by counter is an error.
// - selecting an event the counter cannot count is an error.
// - overflow interrupt or global freeze requested without support is an error.
// - per-counter capabilities replace global interrupt and freeze support bits in the enable checks when set.
// - programming an unsupported filter type is an error.
// - filter paired with event that disallows it is an error.
// - overflow interrupt only when interrupt support bit is one.
// - generating an interrupt sets the pending status bit.
// - writing one to pending bit clears it.
// - each overflow status bit sets on its own counter's wrap; write one clears each bit.
// - interrupt status and interrupt control reads wait for in-flight messages.
// - reported event group count is at most fifteen.
// - group 0 encodes cycles, requests, walk, backpressure, occupancies.
// - group 1 encodes reads, memory backpressure, page requests; no filters.
// - group 2 encodes cache lookups and hits; nonleaf hits take filter.
// - group 4 encodes interrupt cache lookups and hits; no filters.
// - enabled counter wrapping past zero sets its overflow bit.
// - several selected events add together into one counter.
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pmc_counters
  import pmc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PMC_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] evt_g0_i,
  input wire logic [7:0] evt_g1_i,
  input wire logic [7:0] evt_g2_i,
  input wire logic [7:0] evt_g4_i,
  input wire logic msg_busy_i,
  output logic irq_msg_o
);
  // ****************************************
  // state
  // ****************************************
  pmc_state_t s_reg, s_next;
  logic msg_reg, msg_next;
  logic [31:0] cap;
  logic [31:0] ccap;
  logic acc, wr, rd_wait;
  logic [31:0] wmask;
  assign cap = `PMC_CAP_RESET;
  assign ccap = `PMC_CCAP_RESET;
  assign acc = wb_cyc_i && wb_stb_i && !s_reg.ack;
  assign wr = acc && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign rd_wait = ((wb_adr_i == `PMC_OFF_IRQ_STS) || (wb_adr_i == `PMC_OFF_IRQ_CTL))
                   && (msg_reg || msg_busy_i);

  // ****************************************
  // per-counter event sum and check
  // ****************************************
  logic [`PMC_NCNT-1:0][`PMC_CW-1:0] inc;
  logic [`PMC_NCNT-1:0] chk_fail;
  genvar g;
  generate
    for (g = 0; g < `PMC_NCNT; g++)
    begin : gen_cnt
      logic [7:0] ev;
      logic [`PMC_CFG_ES_W-1:0] gmask, fmask, es;
      logic [3:0] pop;
      logic multi, flt_on, overflow_irq_supported, global_freeze_supported;
      always_comb
      begin
        es = s_reg.cfg[g].es;
        unique case (s_reg.cfg[g].egi)
          3'h0:
          begin
            ev = evt_g0_i;
            gmask = `PMC_MASK_G0;
            fmask = `PMC_FLT_G0;
          end
          3'h1:
          begin
            ev = evt_g1_i;
            gmask = `PMC_MASK_G1;
            fmask = '0;
          end
          3'h2:
          begin
            ev = evt_g2_i;
            gmask = `PMC_MASK_G2;
            fmask = `PMC_FLT_G2;
          end
          3'h4:
          begin
            ev = evt_g4_i;
            gmask = `PMC_MASK_G4;
            fmask = '0;
          end
          default:
          begin
            ev = 8'h00;
            gmask = '0;
            fmask = '0;
          end
        endcase
        pop = '0;
        for (int b = 0; b < 8; b++)
          pop = pop + 4'(ev[b] & es[b]);
        inc[g] = `PMC_CW'(pop);
        multi = ($countones(es) > 1);
        flt_on = |s_reg.flt[g];
        overflow_irq_supported = ccap[`PMC_CCAP_PCC_BIT] ? ccap[`PMC_CAP_IOS_BIT] : cap[`PMC_CAP_IOS_BIT];
        global_freeze_supported = ccap[`PMC_CCAP_PCC_BIT] ? ccap[`PMC_CAP_GFS_BIT] : cap[`PMC_CAP_GFS_BIT];
        chk_fail[g] = (multi && flt_on)
          || (gmask == '0)
          || |(es & ~gmask)
          || (s_reg.cfg[g].iov && !overflow_irq_supported) || (s_reg.cfg[g].gfo && !global_freeze_supported)
          || |(s_reg.flt[g] & ~cap[`PMC_CAP_FLT_LSB +: `PMC_FLT_W])
          || (flt_on && !(|(es & fmask)));
      end
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    int idx;
    logic [`PMC_CW:0] sum;
    logic [`PMC_NCNT-1:0] ovf_set;
    idx = 0;
    sum = '0;
    ovf_set = '0;
    s_next = s_reg;
    s_next.ack = 1'b0;
    msg_next = 1'b0;
    for (int i = 0; i < `PMC_NCNT; i++)
    begin
      sum = {1'b0, s_reg.cnt[i]} + {1'b0, inc[i]};
      if (s_reg.cfg[i].en)
      begin
        s_next.cnt[i] = sum[`PMC_CW-1:0];
        if (sum[`PMC_CW])
          ovf_set[i] = 1'b1;
      end
    end
    if (wr && !s_reg.ack)
    begin
      for (int i = 0; i < `PMC_NCNT; i++)
      begin
        if (wb_adr_i == `PMC_OFF_CFG0 + 8'(4 * i))
        begin
          s_next.cfg[i].iov = wb_dat_i[`PMC_CFG_IOV_BIT];
          s_next.cfg[i].gfo = wb_dat_i[`PMC_CFG_GFO_BIT];
          s_next.cfg[i].egi = wb_dat_i[`PMC_CFG_EGI_LSB +: 3];
          s_next.cfg[i].es = wb_dat_i[`PMC_CFG_ES_W-1:0];
          if (!wb_dat_i[`PMC_CFG_EN_BIT])
            s_next.cfg[i].en = 1'b0;
        end
        if (wb_adr_i == `PMC_OFF_FLT0 + 8'(4 * i))
          s_next.flt[i] = wb_dat_i[`PMC_FLT_W-1:0];
        if (wb_adr_i == `PMC_OFF_CNT0 + 8'(4 * i))
          s_next.cnt[i] = (s_reg.cnt[i] & ~wmask) | (wb_dat_i & wmask);
      end
      unique case (wb_adr_i)
        `PMC_OFF_IRQ_CTL: s_next.irq_mask = wb_dat_i[0];
        `PMC_OFF_IRQ_STS:
          if (wb_dat_i[0])
            s_next.pend = 1'b0;
        `PMC_OFF_OVF_STS: s_next.ovf = s_reg.ovf & ~wb_dat_i[`PMC_NCNT-1:0];
        `PMC_OFF_CMD:
        begin
          idx = int'(wb_dat_i[7:0]);
          if (idx >= `PMC_NCNT)
            s_next.resp = `PMC_RESP_ERR;
          else if (chk_fail[idx])
            s_next.resp = `PMC_RESP_ERR;
          else
          begin
            s_next.resp = `PMC_RESP_OK;
            s_next.cfg[idx].en = 1'b1;
          end
        end
        default: ;
      endcase
    end
    s_next.ovf = s_next.ovf | ovf_set;
    for (int i = 0; i < `PMC_NCNT; i++)
    begin
      if (ovf_set[i] && s_reg.cfg[i].iov && cap[`PMC_CAP_IOS_BIT] && !s_reg.irq_mask)
      begin
        msg_next = 1'b1;
        s_next.pend = 1'b1;
      end
    end
    if (acc && !(rd_wait && !wb_we_i))
    begin
      s_next.ack = 1'b1;
      s_next.rdata = 32'h0000_0000;
      for (int i = 0; i < `PMC_NCNT; i++)
      begin
        if (wb_adr_i == `PMC_OFF_CFG0 + 8'(4 * i))
          s_next.rdata = {s_reg.cfg[i].en, s_reg.cfg[i].iov, s_reg.cfg[i].gfo,
                          1'b0, s_reg.cfg[i].egi[2:0], s_reg.cfg[i].es[24:0]};
        if (wb_adr_i == `PMC_OFF_FLT0 + 8'(4 * i))
          s_next.rdata = {29'h0, s_reg.flt[i]};
        if (wb_adr_i == `PMC_OFF_CNT0 + 8'(4 * i))
          s_next.rdata = s_reg.cnt[i];
      end
      unique case (wb_adr_i)
        `PMC_OFF_CAP: s_next.rdata = cap;
        `PMC_OFF_CCAP: s_next.rdata = ccap;
        `PMC_OFF_IRQ_CTL: s_next.rdata = {31'h0, s_reg.irq_mask};
        `PMC_OFF_IRQ_STS: s_next.rdata = {31'h0, s_reg.pend};
        `PMC_OFF_OVF_STS: s_next.rdata = {28'h0, s_reg.ovf};
        `PMC_OFF_RESP: s_next.rdata = {30'h0, s_reg.resp};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_reg <= '0;
      msg_reg <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
      msg_reg <= msg_next;
    end
  end

  assign wb_dat_o = s_reg.rdata;
  assign wb_ack_o = s_reg.ack;
  assign irq_msg_o = msg_reg;
endmodule : pmc_counters
`default_nettype wire

//--- pmc_counters_properties.sv
// checker for bus answers and status reads of the counter block
// assumes binding onto the ports of pmc_counters
`timescale 1ns/1ps
`default_nettype none
`include "pmc_consts.svh"
module pmc_counters_properties
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`PMC_ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic msg_busy_i
);
  // ****************
  // request decode
  // ****************
  logic rd;
  logic slow;
  assign rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign slow = rd && (wb_adr_i == 8'h08 || wb_adr_i == 8'h0C);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !slow |=> wb_ack_o)
    else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  busy_hold_a: assert property (slow && msg_busy_i |=> !wb_ack_o)
    else $error("status read answered while message in flight");
  cap_value_a: assert property (rd && wb_adr_i == 8'h00 |=> wb_dat_o == 32'h0001_0437)
    else $error("capability value wrong");
  resp_code_a: assert property (rd && wb_adr_i == 8'h18 |=> wb_dat_o[31:2] == 30'h0)
    else $error("response code out of range");
  ovf_width_a: assert property (rd && wb_adr_i == 8'h10 |=> wb_dat_o[31:4] == 28'h0)
    else $error("overflow status has stray bits");
  unmapped_zero_a: assert property (rd && wb_adr_i[7:5] == 3'h1 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  cover property (slow && msg_busy_i);
  cover property (rd && wb_adr_i == 8'h18);
  cover property (rd && wb_adr_i == 8'h10);
endmodule : pmc_counters_properties
`default_nettype wire

//--- pmc_pkg.sv
// types shared by the counter block
// assumes pmc_consts.svh beside it
`include "pmc_consts.svh"
package pmc_pkg;
  typedef struct packed {
    logic en;
    logic iov;
    logic gfo;
    logic [2:0] egi;
    logic [`PMC_CFG_ES_W-1:0] es;
  } pmc_cfg_t;
  typedef struct packed {
    logic [`PMC_NCNT-1:0][`PMC_CW-1:0] cnt;
    pmc_cfg_t [`PMC_NCNT-1:0] cfg;
    logic [`PMC_NCNT-1:0][`PMC_FLT_W-1:0] flt;
    logic [`PMC_NCNT-1:0] ovf;
    logic pend;
    logic irq_mask;
    logic [1:0] resp;
    logic [31:0] rdata;
    logic ack;
  } pmc_state_t;
endpackage : pmc_pkg

//--- test_pmc_counters.sv
// self-checking bench for the counter block over wishbone
// assumes pmc_pkg, pmc_counters and the checker compiled before
`timescale 1ns/1ps
`default_nettype none
module test_pmc_counters;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] g0 = 8'h00;
  logic [7:0] g4 = 8'h00;
  logic busy = 1'b0;
  logic irq;
  logic [31:0] v;
  int mismatches = 0;
  int checks_done = 0;
  int irqs = 0;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (irq === 1'b1)
      irqs <= irqs + 1;
  pmc_counters dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .evt_g0_i(g0), .evt_g1_i(8'h00), .evt_g2_i(8'h00), .evt_g4_i(g4),
    .msg_busy_i(busy), .irq_msg_o(irq));
  // ****************
  // tasks
  // ****************
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      mismatches++;
      close_out();
    end
    v = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic enable_cmd(input logic [7:0] i, input logic [31:0] cfg,
    input logic [2:0] flt, input logic [1:0] exp);
    logic [7:0] ca;
    ca = 8'h40 + {4'h0, i[1:0], 2'b00};
    bus(1'b1, ca, cfg);
    bus(1'b1, ca + 8'h10, {29'h0, flt});
    bus(1'b1, 8'h14, {24'h0, i});
    bus(1'b0, 8'h18, 32'h0);
    check("response", v, {30'h0, exp});
    bus(1'b0, ca, 32'h0);
    check("enable bit", {31'h0, v[31]}, {31'h0, i < 8'd4 && exp == 2'h1});
  endtask : enable_cmd
  // ****************
  // sequence
  // ****************
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h00, 32'h0);
    check("capability", v, 32'h0001_0437);
    bus(1'b1, 8'h24, 32'h5);
    bus(1'b0, 8'h24, 32'h0);
    check("unmapped", v, 32'h0);
    enable_cmd(8'd4, 32'h0, 3'h0, 2'h2);
    enable_cmd(8'd2, 32'h0000_0003, 3'h1, 2'h2);
    enable_cmd(8'd2, 32'h3000_0001, 3'h0, 2'h2);
    enable_cmd(8'd2, 32'h1000_0002, 3'h0, 2'h2);
    enable_cmd(8'd2, 32'h0000_0002, 3'h2, 2'h2);
    enable_cmd(8'd2, 32'h0000_0001, 3'h1, 2'h2);
    enable_cmd(8'd2, 32'h2000_0020, 3'h4, 2'h1);
    enable_cmd(8'd3, 32'h1000_0061, 3'h0, 2'h1);
    bus(1'b1, 8'h60, 32'hFFFF_FFFF);
    bus(1'b1, 8'h64, 32'hFFFF_FFFE);
    enable_cmd(8'd0, 32'h4000_0007, 3'h0, 2'h1);
    enable_cmd(8'd1, 32'h0000_0021, 3'h0, 2'h1);
    g0 <= 8'h21;
    g4 <= 8'h02;
    @(posedge clk_i);
    g0 <= 8'h00;
    g4 <= 8'h00;
    bus(1'b0, 8'h64, 32'h0);
    check("summed count", v, 32'h0);
    bus(1'b0, 8'h60, 32'h0);
    check("wrapped count", v, 32'h0);
    bus(1'b0, 8'h10, 32'h0);
    check("overflow status", v, 32'h3);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b0, 8'h10, 32'h0);
    check("overflow after clear", v, 32'h2);
    busy <= 1'b1;
    fork
      bus(1'b0, 8'h0C, 32'h0);
      begin
        repeat (3)
        begin
          @(posedge clk_i);
          check("held ack", {31'h0, ack}, 32'h0);
        end
        busy <= 1'b0;
      end
    join
    check("pending", v, 32'h1);
    check("messages", irqs, 32'h1);
    bus(1'b1, 8'h0C, 32'h1);
    bus(1'b0, 8'h0C, 32'h0);
    check("pending cleared", v, 32'h0);
    close_out();
  end
endmodule : test_pmc_counters
bind pmc_counters pmc_counters_properties chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .msg_busy_i(msg_busy_i));
`default_nettype wire
